/* hdl/spmp_pkg.sv */
// package: register map, field positions, state and pin structs of the serial port
package spmp_pkg;

  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_CON1 = 8'h04;
  localparam logic [7:0] OFF_CON2 = 8'h08;
  localparam logic [7:0] OFF_BUF = 8'h0c;

  localparam int ST_EN = 15;
  localparam int ST_SIDL = 13;
  localparam int ST_OVF = 6;
  localparam int ST_TBF = 1;
  localparam int ST_RBF = 0;

  localparam int C1_CLOCK_PIN_DISABLE = 12;
  localparam int C1_DATA_OUT_PIN_DISABLE = 11;
  localparam int C1_WIDE = 10;
  localparam int C1_SMP = 9;
  localparam int C1_CKE = 8;
  localparam int C1_SLAVE_SELECT_ENABLE = 7;
  localparam int C1_CKP = 6;
  localparam int C1_MST = 5;
  localparam int C1_SPRE = 2;
  localparam int C1_PPRE = 0;
  localparam logic [15:0] C1_MASK = 16'h1fff;

  localparam int C2_FRM = 15;
  localparam int C2_FSD = 14;
  localparam int C2_FPOL = 13;
  localparam int C2_FDLY = 1;
  localparam logic [15:0] C2_MASK = 16'he002;

  localparam logic [5:0] HALF_BYTE = 6'h10;
  localparam logic [5:0] HALF_WORD = 6'h20;
  localparam logic [5:0] PRE_LAST = 6'h01;

  typedef enum logic [1:0] {SPMP_IDLE, SPMP_PRE, SPMP_RUN} spmp_st_t;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
  } spmp_pin_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } spmp_pin_out_t;

  typedef struct packed {
    logic en;
    logic sidl;
    logic ovf;
    logic tbf;
    logic rbf;
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] txb;
    logic [15:0] rxb;
    logic [15:0] sr;
    spmp_st_t st;
    logic [5:0] hcnt;
    logic [9:0] dcnt;
    logic phase;
    logic [2:0] sck_s;
    logic [1:0] sdi_s;
    logic [1:0] ss_s;
    logic wr;
    logic [7:0] waddr;
    logic [31:0] hrdata;
    logic ready;
    spmp_pin_out_t pins;
  } spmp_state_t;

  // serial half period in hclk cycles: primary ratio times secondary ratio
  function automatic logic [9:0] spmp_div(input logic [1:0] ppre, input logic [2:0] spre);
    logic [6:0] pri;
    logic [3:0] sec;
    pri = 7'h01 << {ppre ^ 2'h3, 1'b0};
    sec = 4'h8 - {1'b0, spre};
    return 10'(pri) * 10'(sec);
  endfunction : spmp_div

endpackage : spmp_pkg

/* hdl/spmp_top.sv */
// serial peripheral port, master or slave, with ahb-lite register slave
`timescale 1ns/1ps
module spmp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic idle_mode,
  input wire spmp_pkg::spmp_pin_in_t pin_in,
  output spmp_pkg::spmp_pin_out_t pin_out
);

  spmp_pkg::spmp_state_t s;
  spmp_pkg::spmp_state_t n;
  logic acc;
  logic mst;
  logic fm;
  logic fsl;
  logic halt;
  logic run_ok;
  logic clk_run;
  logic mtick;
  logic sedge;
  logic evt;
  logic lead;
  logic samp;
  logic late;
  logic wide;
  logic sdi;
  logic start;
  logic done;
  logic [5:0] last;
  logic [15:0] word;

  function automatic logic msb_of(input logic [15:0] v, input logic w);
    return w ? v[15] : v[7];
  endfunction : msb_of

  assign hreadyout = s.ready;
  assign hresp = 1'b0 & s.ready;
  assign hrdata = s.hrdata;
  assign pin_out = s.pins;

  always_comb
  begin
    n = s;
    start = 1'b0;
    done = 1'b0;
    word = '0;
    mst = s.con1[spmp_pkg::C1_MST];
    fm = s.con2[spmp_pkg::C2_FRM] & ~s.con2[spmp_pkg::C2_FSD] & mst;
    fsl = s.con2[spmp_pkg::C2_FRM] & s.con2[spmp_pkg::C2_FSD];
    wide = s.con1[spmp_pkg::C1_WIDE];
    last = wide ? spmp_pkg::HALF_WORD : spmp_pkg::HALF_BYTE;
    late = mst & s.con1[spmp_pkg::C1_SMP];
    halt = s.sidl & idle_mode;
    run_ok = s.en & ~halt;
    sdi = s.sdi_s[1];
    // input synchronisers
    n.sck_s = {s.sck_s[1:0], pin_in.sck};
    n.sdi_s = {s.sdi_s[0], pin_in.sdi};
    n.ss_s = {s.ss_s[0], pin_in.ss_n};
    // master clock generator
    clk_run = s.en & mst & ~s.con1[spmp_pkg::C1_CLOCK_PIN_DISABLE]
      & ((s.st != spmp_pkg::SPMP_IDLE) | fm);
    mtick = clk_run & ~halt & (s.dcnt == 10'h000);
    if (!clk_run || mtick)
    begin
      n.dcnt = spmp_pkg::spmp_div(s.con1[spmp_pkg::C1_PPRE +: 2],
        s.con1[spmp_pkg::C1_SPRE +: 3]) - 10'h001;
    end
    else if (!halt)
    begin
      n.dcnt = s.dcnt - 10'h001;
    end
    if (!clk_run)
    begin
      n.phase = 1'b0;
    end
    else if (mtick && !(s.st == spmp_pkg::SPMP_RUN && s.hcnt == last && !fm))
    begin
      n.phase = ~s.phase;
    end
    sedge = s.sck_s[1] ^ s.sck_s[2];
    evt = mst ? mtick : (run_ok & sedge);
    lead = mst ? ~s.phase : (s.sck_s[1] != s.con1[spmp_pkg::C1_CKP]);
    samp = s.con1[spmp_pkg::C1_CKE] ? lead : ~lead;
    // ahb-lite address phase: read data and read side effects
    acc = hsel & hready & htrans[1];
    n.wr = acc & hwrite;
    n.waddr = haddr[7:0];
    n.hrdata = '0;
    if (acc && !hwrite)
    begin
      case (haddr[7:0])
        spmp_pkg::OFF_STAT:
        begin
          n.hrdata[spmp_pkg::ST_EN] = s.en;
          n.hrdata[spmp_pkg::ST_SIDL] = s.sidl;
          n.hrdata[spmp_pkg::ST_OVF] = s.ovf;
          n.hrdata[spmp_pkg::ST_TBF] = s.tbf;
          n.hrdata[spmp_pkg::ST_RBF] = s.rbf;
        end
        spmp_pkg::OFF_CON1: n.hrdata[15:0] = s.con1;
        spmp_pkg::OFF_CON2: n.hrdata[15:0] = s.con2;
        spmp_pkg::OFF_BUF:
        begin
          n.hrdata[15:0] = s.rxb;
          n.rbf = 1'b0;
        end
        default: n.hrdata = '0;
      endcase
    end
    // ahb-lite data phase: control writes
    if (s.wr)
    begin
      case (s.waddr)
        spmp_pkg::OFF_STAT:
        begin
          n.en = hwdata[spmp_pkg::ST_EN];
          n.sidl = hwdata[spmp_pkg::ST_SIDL];
          n.ovf = s.ovf & hwdata[spmp_pkg::ST_OVF];
        end
        spmp_pkg::OFF_CON1: n.con1 = hwdata[15:0] & spmp_pkg::C1_MASK;
        spmp_pkg::OFF_CON2: n.con2 = hwdata[15:0] & spmp_pkg::C2_MASK;
        default: n.wr = 1'b0;
      endcase
    end
    // shift engine
    unique case (s.st)
      spmp_pkg::SPMP_IDLE:
      begin
        if (mst)
        begin
          start = run_ok & ~s.con1[spmp_pkg::C1_CLOCK_PIN_DISABLE] & s.tbf
            & (fm ? (mtick & s.phase) : 1'b1);
        end
        else
        begin
          start = run_ok
            & ((s.con1[spmp_pkg::C1_SLAVE_SELECT_ENABLE] & ~fsl) ? ~s.ss_s[1] : 1'b1)
            & (fsl ? (s.ss_s[1] == s.con2[spmp_pkg::C2_FPOL]) : 1'b1);
        end
      end
      spmp_pkg::SPMP_PRE:
      begin
        if (evt)
        begin
          n.hcnt = s.hcnt + 6'h01;
          if (s.hcnt == spmp_pkg::PRE_LAST)
          begin
            n.hcnt = '0;
            n.st = spmp_pkg::SPMP_RUN;
          end
        end
      end
      spmp_pkg::SPMP_RUN:
      begin
        if (!mst && s.con1[spmp_pkg::C1_SLAVE_SELECT_ENABLE] && !fsl && s.ss_s[1])
        begin
          n.st = spmp_pkg::SPMP_IDLE;
          n.hcnt = '0;
        end
        else if (evt)
        begin
          if (mst && s.hcnt == last)
          begin
            if (late && !s.con1[spmp_pkg::C1_CKE])
            begin
              n.sr[0] = sdi;
            end
            done = 1'b1;
          end
          else
          begin
            n.hcnt = s.hcnt + 6'h01;
            if (samp)
            begin
              n.sr = {s.sr[14:0], late ? 1'b0 : sdi};
            end
            else
            begin
              if (late && s.hcnt != 6'h00)
              begin
                n.sr[0] = sdi;
              end
              n.pins.sdo_o = msb_of(n.sr, wide);
            end
            done = ~mst & (n.hcnt == last);
          end
        end
        else if (!mst && run_ok && s.hcnt == 6'h00 && s.tbf)
        begin
          n.sr = s.txb;
          n.tbf = 1'b0;
          n.pins.sdo_o = msb_of(s.txb, wide);
        end
      end
      default: n.st = spmp_pkg::SPMP_IDLE;
    endcase
    if (start)
    begin
      if (s.tbf)
      begin
        n.sr = s.txb;
        n.tbf = 1'b0;
        n.pins.sdo_o = msb_of(s.txb, wide);
      end
      n.hcnt = '0;
      n.st = (s.con2[spmp_pkg::C2_FRM] && !s.con2[spmp_pkg::C2_FDLY])
        ? spmp_pkg::SPMP_PRE : spmp_pkg::SPMP_RUN;
    end
    if (done)
    begin
      word = wide ? n.sr : {8'h00, n.sr[7:0]};
      n.st = spmp_pkg::SPMP_IDLE;
      n.hcnt = '0;
      if (s.rbf && n.rbf)
      begin
        n.ovf = 1'b1;
      end
      else
      begin
        n.rxb = word;
        n.rbf = 1'b1;
      end
    end
    if (!s.en)
    begin
      n.st = spmp_pkg::SPMP_IDLE;
      n.hcnt = '0;
    end
    // buffer write wins over the tbf clear by the load of the old word
    if (s.wr && s.waddr == spmp_pkg::OFF_BUF)
    begin
      n.txb = hwdata[15:0];
      n.tbf = 1'b1;
    end
    // pin drivers
    n.pins.sck_o = s.con1[spmp_pkg::C1_CKP] ^ n.phase;
    n.pins.sck_oe = s.en & mst & ~s.con1[spmp_pkg::C1_CLOCK_PIN_DISABLE];
    n.pins.sdo_oe = s.en & ~s.con1[spmp_pkg::C1_DATA_OUT_PIN_DISABLE];
    n.pins.ss_n_oe = s.en & fm;
    n.pins.ss_n_o = ~s.con2[spmp_pkg::C2_FPOL]
      ^ (fm & ((n.st == spmp_pkg::SPMP_PRE)
      | (n.st == spmp_pkg::SPMP_RUN && s.con2[spmp_pkg::C2_FDLY]
      && n.hcnt < 6'h02)));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.ready <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_tbf_clear;
    start && s.tbf && !(s.wr && s.waddr == spmp_pkg::OFF_BUF) |=> !s.tbf && s.sr == $past(s.txb);
  endproperty
  a_tbf_clear: assert property (p_tbf_clear) else $error("tx word not moved");

  property p_tbf_set;
    s.wr && s.waddr == spmp_pkg::OFF_BUF |=> s.tbf;
  endproperty
  a_tbf_set: assert property (p_tbf_set) else $error("tx full not set");

  property p_rbf;
    done && !s.rbf |=> s.rbf && s.rxb == $past(word);
  endproperty
  a_rbf: assert property (p_rbf) else $error("rx word not stored");

  property p_ovf;
    done && s.rbf && !(acc && !hwrite && haddr[7:0] == spmp_pkg::OFF_BUF)
      |=> s.ovf && $stable(s.rxb);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_halt;
    halt && s.st == spmp_pkg::SPMP_RUN && !s.wr |=> $stable(s.hcnt) && $stable(s.sr);
  endproperty
  a_halt: assert property (p_halt) else $error("engine ran while halted");

  property p_sck_pin;
    ##1 s.pins.sck_oe == $past(s.en && mst && !s.con1[spmp_pkg::C1_CLOCK_PIN_DISABLE]);
  endproperty
  a_sck_pin: assert property (p_sck_pin) else $error("clock pin drive wrong");

  property p_sdo_pin;
    ##1 s.pins.sdo_oe == $past(s.en && !s.con1[spmp_pkg::C1_DATA_OUT_PIN_DISABLE]);
  endproperty
  a_sdo_pin: assert property (p_sdo_pin) else $error("data pin drive wrong");

  property p_idle_clk;
    s.st == spmp_pkg::SPMP_IDLE && !fm && !start ##1 s.st == spmp_pkg::SPMP_IDLE
      |-> s.pins.sck_o == $past(s.con1[spmp_pkg::C1_CKP]);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock not idle level");

  property p_width;
    done |-> s.hcnt == (mst ? last : last - 6'h01);
  endproperty
  a_width: assert property (p_width) else $error("wrong word length");

endmodule : spmp_top

/* tb/spmp_peer.sv */
// far-side serial device: shifts out a preset word and captures the other
`timescale 1ns/1ps
module spmp_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel,
  input wire logic cpol,
  input wire logic cke,
  input wire logic wide,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [15:0] sh;
  initial miso = 1'b0;
  always @(posedge sel)
  begin
    sh = wide ? tx_word : {tx_word[7:0], 8'h00};
    rx_word = 16'h0000;
    if (cke)
    begin
      miso = sh[15];
      sh = sh << 1;
    end
  end
  always @(negedge sel) miso = ~miso;
  always @(sck)
  begin
    if (sel && ((sck !== cpol) ^ cke))
    begin
      miso = sh[15];
      sh = sh << 1;
    end
    else if (sel)
      rx_word = {rx_word[14:0], mosi};
  end
endmodule : spmp_peer

/* tb/spi_master_slave_port_bench.sv */
// bench: register access and master transfers against the peer model
`timescale 1ns/1ps
module spi_master_slave_port_bench;
  typedef struct {logic [15:0] con1; logic [15:0] tx; logic [15:0] peer;} spmp_row_t;
  logic hclk, hresetn, hsel, hwrite, idle_mode, sel, hreadyout, hresp, miso, last_sck;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] con1, peer_tx, peer_rx;
  wire logic hready;
  wire logic sck_w;
  wire logic mosi_w;
  spmp_pkg::spmp_pin_in_t pin_in;
  spmp_pkg::spmp_pin_out_t pin_out;
  int miscompares, checks, cycles, tog;
  spmp_row_t rows [5];
  assign hready = hreadyout;
  assign sck_w = pin_out.sck_oe ? pin_out.sck_o : con1[spmp_pkg::C1_CKP];
  assign mosi_w = pin_out.sdo_oe ? pin_out.sdo_o : 1'b1;
  assign pin_in = '{sck: sck_w, sdi: miso, ss_n: 1'b1};

  spmp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
    .pin_in(pin_in), .pin_out(pin_out));
  spmp_peer u_peer (.sck(sck_w), .mosi(mosi_w), .sel(sel), .cpol(con1[spmp_pkg::C1_CKP]),
    .cke(con1[spmp_pkg::C1_CKE]), .wide(con1[spmp_pkg::C1_WIDE]), .tx_word(peer_tx),
    .miso(miso), .rx_word(peer_rx));

  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    bus(a, 1'b0, 16'h0000);
    check(rd, {16'h0000, e});
  endtask : rd_chk

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    bus(spmp_pkg::OFF_STAT, 1'b0, 16'h0000);
    while (rd[b] !== 1'b1 && n < 150)
    begin
      bus(spmp_pkg::OFF_STAT, 1'b0, 16'h0000);
      n++;
    end
  endtask : wait_flag

  task automatic run(input spmp_row_t r);
    logic w;
    w = r.con1[spmp_pkg::C1_WIDE];
    con1 <= r.con1;
    peer_tx <= r.peer;
    wr(spmp_pkg::OFF_CON1, r.con1);
    wr(spmp_pkg::OFF_STAT, 16'h8000);
    sel <= 1'b1;
    wr(spmp_pkg::OFF_BUF, r.tx);
    wait_flag(0);
    rd_chk(spmp_pkg::OFF_STAT, 16'h8001);
    rd_chk(spmp_pkg::OFF_BUF, w ? r.peer : {8'h00, r.peer[7:0]});
    check({16'h0000, peer_rx}, {16'h0000, w ? r.tx : {8'h00, r.tx[7:0]}});
    rd_chk(spmp_pkg::OFF_STAT, 16'h8000);
    sel <= 1'b0;
    wr(spmp_pkg::OFF_STAT, 16'h0000);
  endtask : run

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    idle_mode = 1'b0;
    sel = 1'b0;
    con1 = 16'h0000;
    peer_tx = 16'h0000;
    rows = '{'{16'h003e, 16'h00a5, 16'h005a}, '{16'h047e, 16'hc3e1, 16'h1e7c},
      '{16'h053e, 16'h8001, 16'h7ffe}, '{16'h017e, 16'h0081, 16'h00c4},
      '{16'h023e, 16'h0033, 16'h00f0}};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(spmp_pkg::OFF_STAT, 16'h0000);
    check({29'h0, pin_out.sck_oe, pin_out.sdo_oe, pin_out.ss_n_oe}, 32'h0);
    check({30'h0, hreadyout, hresp}, 32'h2);
    wr(spmp_pkg::OFF_CON1, 16'hffff);
    rd_chk(spmp_pkg::OFF_CON1, 16'h1fff);
    wr(spmp_pkg::OFF_CON2, 16'hffff);
    rd_chk(spmp_pkg::OFF_CON2, 16'he002);
    wr(spmp_pkg::OFF_CON2, 16'h0000);
    wr(spmp_pkg::OFF_STAT, 16'hffff);
    rd_chk(spmp_pkg::OFF_STAT, 16'ha000);
    wr(spmp_pkg::OFF_STAT, 16'h0000);
    wr(8'h10, 16'hffff);
    rd_chk(8'h10, 16'h0000);
    foreach (rows[i]) run(rows[i]);
    // held start while the clock is disabled, then released
    con1 <= 16'h103e;
    wr(spmp_pkg::OFF_CON1, 16'h103e);
    wr(spmp_pkg::OFF_STAT, 16'h8000);
    sel <= 1'b1;
    wr(spmp_pkg::OFF_BUF, 16'h00a5);
    rd_chk(spmp_pkg::OFF_STAT, 16'h8002);
    check({31'h0, pin_out.sck_oe}, 32'h0);
    con1 <= 16'h003e;
    wr(spmp_pkg::OFF_CON1, 16'h003e);
    wait_flag(0);
    rd_chk(spmp_pkg::OFF_STAT, 16'h8001);
    check({16'h0000, peer_rx}, 32'h000000a5);
    // second word into an unread buffer, first held back by idle
    sel <= 1'b0;
    wr(spmp_pkg::OFF_STAT, 16'ha000);
    sel <= 1'b1;
    idle_mode <= 1'b1;
    wr(spmp_pkg::OFF_BUF, 16'h003c);
    repeat (150) @(posedge hclk);
    bus(spmp_pkg::OFF_STAT, 1'b0, 16'h0000);
    check({31'h0, rd[spmp_pkg::ST_OVF]}, 32'h0);
    idle_mode <= 1'b0;
    wait_flag(6);
    rd_chk(spmp_pkg::OFF_STAT, 16'ha041);
    rd_chk(spmp_pkg::OFF_BUF, 16'h00f0);
    rd_chk(spmp_pkg::OFF_STAT, 16'ha040);
    wr(spmp_pkg::OFF_STAT, 16'ha000);
    rd_chk(spmp_pkg::OFF_STAT, 16'ha000);
    sel <= 1'b0;
    // slave role with data output disabled
    wr(spmp_pkg::OFF_STAT, 16'h0000);
    con1 <= 16'h0800;
    wr(spmp_pkg::OFF_CON1, 16'h0800);
    wr(spmp_pkg::OFF_STAT, 16'h8000);
    repeat (2) @(posedge hclk);
    check({30'h0, pin_out.sck_oe, pin_out.sdo_oe}, 32'h0);
    wr(spmp_pkg::OFF_CON1, 16'h0000);
    repeat (2) @(posedge hclk);
    check({30'h0, pin_out.sck_oe, pin_out.sdo_oe}, 32'h1);
    // framed master: clock keeps running with no data
    wr(spmp_pkg::OFF_STAT, 16'h0000);
    wr(spmp_pkg::OFF_CON2, 16'h8000);
    con1 <= 16'h003e;
    wr(spmp_pkg::OFF_CON1, 16'h003e);
    wr(spmp_pkg::OFF_STAT, 16'h8000);
    tog = 0;
    last_sck = pin_out.sck_o;
    repeat (64)
    begin
      @(posedge hclk);
      if (pin_out.sck_o !== last_sck)
        tog++;
      last_sck = pin_out.sck_o;
    end
    check({31'h0, tog > 4}, 32'h1);
    check({31'h0, pin_out.ss_n_oe}, 32'h1);
    close_out();
  end
endmodule : spi_master_slave_port_bench
